// file: hdl/sbpc_pkg.sv
// constants, types and carriers for the burst and protection controller
package sbpc_pkg;
  // timing
  localparam int CLK_HZ        = 40_000_000;
  localparam int FILT_NS       = 8000;
  localparam int FILT_CYC      = (FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int FILT_W        = 9;
  localparam int BLANK_MS      = 20;
  localparam int BLANK_CYC     = BLANK_MS * (CLK_HZ / 1000);
  localparam int LATCH_IGN_MS  = 1;
  localparam int LATCH_IGN_CYC = LATCH_IGN_MS * (CLK_HZ / 1000);
  localparam int CNT_W         = 20;
  // register map
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_STATUS  = 8'h04;
  localparam logic [7:0]  OFF_FAULT   = 8'h08;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0003;
  localparam int          CTRL_BURST  = 0;
  localparam int          CTRL_EXTLAT = 1;
  localparam int          FLT_W       = 6;
  localparam int          FLT_VCC_OV  = 0;
  localparam int          FLT_TEMP    = 1;
  localparam int          FLT_SHORT   = 2;
  localparam int          FLT_EXT     = 3;
  localparam int          FLT_OVLD    = 4;
  localparam int          FLT_UV      = 5;

  typedef enum logic [2:0] {
    ST_RESTART, ST_START, ST_NORMAL, ST_BURST, ST_LATCHED
  } sbpc_state_e;

  // comparator and analogue results, all asynchronous
  typedef struct packed {
    logic fb_low;        // feedback below 1.35 V
    logic fb_high;       // feedback above 4.5 V
    logic burst_up;      // burst upper comparator, above 3.61 V
    logic burst_low;     // burst lower comparator, down to 3.0 V
    logic vcc_over;      // supply above 24 V
    logic vcc_uv;        // supply undervoltage
    logic vcc_below_on;  // supply below 10.5 V
    logic vcc_above_off; // supply above 18 V
    logic vcc_unlatch;   // supply below 6.23 V
    logic over_temp;     // junction above shutdown threshold
    logic sec_short;     // current sense above 1.66 V
    logic bl_low;        // blanking pin below 0.1 V
    logic bl_high;       // blanking pin reached 4.0 V
    logic ss_done;       // soft start finished
  } sbpc_cmp_s;

  // control outputs toward the analogue section
  typedef struct packed {
    logic gate_en;       // gate driver enable
    logic bias_en;       // internal bias enable
    logic startup_cell;  // startup cell on
    logic reduced_limit; // select 0.31 V burst current limit
    logic bl_clamp;      // clamp switch holding blanking pin at 0.9 V
    logic burst_flag;    // burst mode active
  } sbpc_ctl_s;
endpackage : sbpc_pkg

// file: hdl/sbpc_ctrl.sv
// mode control: burst, auto-restart and latched-off supervision with apb access
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module sbpc_ctrl
  import sbpc_pkg::*;
#(
  parameter int BLANK_N = BLANK_CYC,
  parameter int IGN_N   = LATCH_IGN_CYC
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RSTN,
  input  wire sbpc_cmp_s         CMP_IN,
  output sbpc_ctl_s              CTL_OUT,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR
);

  sbpc_cmp_s          meta_q, s;
  sbpc_state_e        state_q, state_d;
  sbpc_ctl_s          ctl_d;
  logic               bias_q, bias_d;
  logic               cell_q, cell_d;
  logic [CNT_W-1:0]   lb_cnt_q, ol_cnt_q, st_cnt_q;
  logic [FILT_W-1:0]  filt_cnt_q [3];
  logic [2:0]         filt_in, filt_out;
  logic               lb_done, ol_done, ign_done;
  logic               ext_latch, latch_req, restart_req;
  logic [FLT_W-1:0]   flt_now, fault_q;
  logic [31:0]        ctrl_q;
  logic               acc, wr_ok;

  // true when a counter has reached its target
  function automatic logic at_count(input logic [CNT_W-1:0] c, input int n);
    return c == CNT_W'(n);
  endfunction : at_count

  // two-flop synchroniser for all comparator results
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      meta_q <= '0;
      s      <= '0;
    end else begin
      meta_q <= CMP_IN;
      s      <= meta_q;
    end
  end

  assign lb_done  = at_count(lb_cnt_q, BLANK_N);
  assign ol_done  = at_count(ol_cnt_q, BLANK_N);
  assign ign_done = at_count(st_cnt_q, IGN_N);

  // light-load blanking counter
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      lb_cnt_q <= '0;
    end else if (state_q != ST_NORMAL || !s.fb_low || !ctrl_q[CTRL_BURST]) begin
      lb_cnt_q <= '0;
    end else if (!lb_done) begin
      lb_cnt_q <= lb_cnt_q + CNT_W'(1);
    end
  end

  // overload blanking counter, saturates at target
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ol_cnt_q <= '0;
    end else if (!(state_q == ST_NORMAL || state_q == ST_BURST) || !s.fb_high) begin
      ol_cnt_q <= '0;
    end else if (!ol_done) begin
      ol_cnt_q <= ol_cnt_q + CNT_W'(1);
    end
  end

  // startup-phase counter for external latch blanking
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_cnt_q <= '0;
    end else if (state_q != ST_START) begin
      st_cnt_q <= '0;
    end else if (!ign_done) begin
      st_cnt_q <= st_cnt_q + CNT_W'(1);
    end
  end

  // spike filter inputs: overvoltage, temperature, restart gate
  // overvoltage qualified by feedback
  assign filt_in[0] = s.vcc_over & s.fb_high;
  assign filt_in[1] = s.over_temp;
  assign filt_in[2] = ol_done & s.bl_high;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < 3; i++) filt_cnt_q[i] <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!filt_in[i]) filt_cnt_q[i] <= '0;
        else if (!filt_out[i]) filt_cnt_q[i] <= filt_cnt_q[i] + FILT_W'(1);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) filt_out[i] = filt_cnt_q[i] == FILT_W'(FILT_CYC);
  end

  // external latch after 1 ms of startup
  assign ext_latch = s.bl_low & ctrl_q[CTRL_EXTLAT] & !(state_q == ST_START && !ign_done);

  assign flt_now[FLT_VCC_OV] = filt_out[0];
  assign flt_now[FLT_TEMP]   = filt_out[1];
  assign flt_now[FLT_SHORT]  = s.sec_short;
  assign flt_now[FLT_EXT]    = ext_latch;
  assign flt_now[FLT_OVLD]   = filt_out[2];
  assign flt_now[FLT_UV]     = s.vcc_uv;
  assign latch_req   = |flt_now[FLT_EXT:FLT_VCC_OV];
  assign restart_req = |flt_now[FLT_UV:FLT_OVLD];

  // next mode, bias and startup cell
  always_comb begin
    state_d = state_q;
    bias_d  = bias_q;
    cell_d  = cell_q;
    case (state_q)
      ST_RESTART: begin
        bias_d = 1'b0;
        cell_d = !s.vcc_above_off;
        if (s.vcc_above_off) begin
          state_d = ST_START;
          bias_d  = 1'b1;
          cell_d  = 1'b0;
        end
      end
      ST_START: begin
        bias_d = 1'b1;
        cell_d = 1'b0;
        if (s.ss_done && ign_done) state_d = ST_NORMAL;
      end
      ST_NORMAL: begin
        bias_d = 1'b1;
        if (lb_done && s.fb_low) begin
          state_d = ST_BURST;
          bias_d  = 1'b0;
        end
      end
      ST_BURST: begin
        if (s.fb_high) begin
          state_d = ST_NORMAL;
          bias_d  = 1'b1;
        end else if (!bias_q && s.burst_up) begin
          bias_d = 1'b1;
        end else if (bias_q && s.burst_low) begin
          bias_d = 1'b0;
        end
      end
      ST_LATCHED: begin
        bias_d = 1'b0;
        if (s.vcc_below_on) cell_d = 1'b1;
        else if (s.vcc_above_off) cell_d = 1'b0;
        if (s.vcc_unlatch) begin
          state_d = ST_RESTART;
          cell_d  = 1'b1;
        end
      end
      default: begin
        state_d = ST_RESTART;
        bias_d  = 1'b0;
        cell_d  = 1'b1;
      end
    endcase
    if (state_q != ST_LATCHED && latch_req) begin
      state_d = ST_LATCHED;
      bias_d  = 1'b0;
      cell_d  = s.vcc_below_on;
    end else if (state_q != ST_LATCHED && state_q != ST_RESTART && restart_req) begin
      state_d = ST_RESTART;
      bias_d  = 1'b0;
      cell_d  = 1'b1;
    end
  end

  // output values derived from next state, clamp from overload timer
  always_comb begin
    ctl_d               = '0;
    ctl_d.bias_en       = bias_d;
    ctl_d.startup_cell  = cell_d;
    ctl_d.gate_en       = (state_d == ST_START) || (state_d == ST_NORMAL) ||
                          (state_d == ST_BURST && bias_d);
    ctl_d.reduced_limit = state_d == ST_BURST;
    ctl_d.burst_flag    = state_d == ST_BURST;
    ctl_d.bl_clamp      = !ol_done;
  end

  // mode registers and outputs
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_RESTART;
      bias_q  <= 1'b0;
      cell_q  <= 1'b1;
      CTL_OUT <= '{gate_en: 1'b0, bias_en: 1'b0, startup_cell: 1'b1,
                   reduced_limit: 1'b0, bl_clamp: 1'b1, burst_flag: 1'b0};
    end else begin
      state_q <= state_d;
      bias_q  <= bias_d;
      cell_q  <= cell_d;
      CTL_OUT <= ctl_d;
    end
  end

  // apb: one wait state, write commits when pready is high
  assign acc   = PSEL & PENABLE;
  assign wr_ok = acc & PREADY & PWRITE;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY  <= 1'b0;
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= acc & !PREADY;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
      if (acc && !PREADY) begin
        case (PADDR)
          OFF_CTRL:   PRDATA <= ctrl_q;
          OFF_STATUS: PRDATA <= {21'h0_0000, 3'(state_q), 2'b00, CTL_OUT};
          OFF_FAULT:  PRDATA <= {26'h000_0000, fault_q};
          default:    PSLVERR <= 1'b1;
        endcase
      end
    end
  end

  // control register
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ok && PADDR == OFF_CTRL && PSTRB[0]) begin
      ctrl_q <= {30'h0000_0000, PWDATA[1:0]};
    end
  end

  // sticky fault causes, write one to clear, new event wins
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fault_q <= '0;
    end else if (wr_ok && PADDR == OFF_FAULT && PSTRB[0]) begin
      fault_q <= (fault_q & ~PWDATA[FLT_W-1:0]) | flt_now;
    end else begin
      fault_q <= fault_q | flt_now;
    end
  end

  property p_lb_clear;
    @(posedge CORE_CLK) disable iff (!RSTN)
    (state_q == ST_NORMAL && !s.fb_low) |=> lb_cnt_q == '0;
  endproperty
  a_lb_clear: assert property (p_lb_clear) else $error("blanking timer not cleared");

  property p_burst_entry;
    @(posedge CORE_CLK) disable iff (!RSTN)
    $rose(state_q == ST_BURST) |-> $past(lb_done) && $past(s.fb_low) && !CTL_OUT.bias_en;
  endproperty
  a_burst_entry: assert property (p_burst_entry) else $error("bad burst entry");

  property p_burst_limit;
    @(posedge CORE_CLK) disable iff (!RSTN)
    CTL_OUT.reduced_limit == (state_q == ST_BURST);
  endproperty
  a_burst_limit: assert property (p_burst_limit) else $error("limit select wrong");

  property p_bias_on;
    @(posedge CORE_CLK) disable iff (!RSTN)
    (state_q == ST_BURST && !bias_q && s.burst_up && !s.fb_high && !latch_req
     && !restart_req) |=> CTL_OUT.bias_en && CTL_OUT.gate_en;
  endproperty
  a_bias_on: assert property (p_bias_on) else $error("burst did not resume");

  property p_burst_exit;
    @(posedge CORE_CLK) disable iff (!RSTN)
    (state_q == ST_BURST && s.fb_high) |=> state_q != ST_BURST && !CTL_OUT.reduced_limit;
  endproperty
  a_burst_exit: assert property (p_burst_exit) else $error("burst not left");

  property p_latch_hold;
    @(posedge CORE_CLK) disable iff (!RSTN)
    (state_q == ST_LATCHED && !s.vcc_unlatch) |=> state_q == ST_LATCHED;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch released early");

  property p_latch_gate;
    @(posedge CORE_CLK) disable iff (!RSTN)
    state_q == ST_LATCHED |-> !CTL_OUT.gate_en && !CTL_OUT.bias_en;
  endproperty
  a_latch_gate: assert property (p_latch_gate) else $error("gate on while latched");

  property p_filter;
    @(posedge CORE_CLK) disable iff (!RSTN)
    $rose(filt_out[1]) |-> $past(filt_in[1], 300) && filt_in[1];
  endproperty
  a_filter: assert property (p_filter) else $error("spike passed filter");

  property p_short;
    @(posedge CORE_CLK) disable iff (!RSTN)
    (s.sec_short && !(state_q == ST_LATCHED && s.vcc_unlatch)) |=> state_q == ST_LATCHED;
  endproperty
  a_short: assert property (p_short) else $error("short not latched");

  property p_bias_off;
    @(posedge CORE_CLK) disable iff (!RSTN)
    (state_q == ST_BURST && bias_q && s.burst_low && !s.fb_high && !latch_req
     && !restart_req) |=> !CTL_OUT.bias_en && !CTL_OUT.gate_en;
  endproperty
  a_bias_off: assert property (p_bias_off) else $error("burst did not pause");

  property p_latch_cell;
    @(posedge CORE_CLK) disable iff (!RSTN)
    (state_q == ST_LATCHED && s.vcc_below_on && !s.vcc_unlatch) |=> CTL_OUT.startup_cell;
  endproperty
  a_latch_cell: assert property (p_latch_cell) else $error("startup cell not on");

  property p_uv_restart;
    @(posedge CORE_CLK) disable iff (!RSTN)
    (s.vcc_uv && !latch_req && state_q != ST_LATCHED && state_q != ST_RESTART)
    |=> state_q == ST_RESTART && !CTL_OUT.gate_en;
  endproperty
  a_uv_restart: assert property (p_uv_restart) else $error("undervoltage not restarted");

  property p_clamp;
    @(posedge CORE_CLK) disable iff (!RSTN)
    ol_done |=> !CTL_OUT.bl_clamp;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp not released");

endmodule : sbpc_ctrl

// file: tb/sbpc_cmp_model.sv
// analogue side model: comparators, blanking pin and latch transistor
`timescale 1ns/1ps
module sbpc_cmp_model
  import sbpc_pkg::*;
#(
  parameter int CAP_N = 40
) (
  input  wire logic      core_clk,
  input  wire sbpc_cmp_s lv,
  input  wire logic      latch_req,
  input  wire sbpc_ctl_s ctl,
  output sbpc_cmp_s      cmp
);
  int chg_q = 0;

  // pin charges from 0.9 V to 4.0 V
  always_ff @(posedge core_clk) begin
    chg_q <= (ctl.bl_clamp || latch_req) ? 0 : chg_q + 1;
  end

  // transistor pulls pin below 0.1 V
  always_comb begin
    cmp         = lv;
    cmp.bl_low  = latch_req;
    cmp.bl_high = !ctl.bl_clamp && !latch_req && (chg_q >= CAP_N);
  end
endmodule : sbpc_cmp_model

// file: tb/testbench.sv
// self-checking bench for the burst and protection controller
`timescale 1ns/1ps
module testbench;
  import sbpc_pkg::*;
  localparam int BN  = 50;
  localparam int IN  = 20;
  localparam int CAP = 40;
  localparam int FL  = 320;
  logic        CORE_CLK  = 1'b0;
  logic        RSTN      = 1'b0;
  sbpc_cmp_s   lv        = '0;
  sbpc_cmp_s   cmp;
  sbpc_ctl_s   ctl;
  logic        lreq      = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        slv;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc       = 0;

  sbpc_cmp_model #(.CAP_N(CAP)) u_model (.core_clk(CORE_CLK), .lv(lv), .latch_req(lreq),
    .ctl(ctl), .cmp(cmp));

  sbpc_ctrl #(.BLANK_N(BN), .IGN_N(IN)) u_dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
    .CMP_IN(cmp), .CTL_OUT(ctl), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr));

  // 40 MHz clock
  always #12.5 CORE_CLK = ~CORE_CLK;

  // cycle ceiling against hangs
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // verdict and end of run
  task automatic tally_and_finish;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, waits for pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge CORE_CLK);
    penable <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    rd      = prdata;
    slv     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cyc_n(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask : cyc_n

  // wait for masked outputs, bounded
  task automatic wctl(input logic [5:0] m, input logic [5:0] v, input int lim);
    int n;
    n = 0;
    while ((ctl & m) !== v && n < lim) begin
      @(posedge CORE_CLK);
      n++;
    end
    chk(ctl & m, v);
  endtask : wctl

  // check state field of status
  task automatic st(input logic [2:0] e);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(rd[10:8], e);
  endtask : st

  // restart to startup to normal, optional startup probes
  task automatic boot(input bit tst);
    lv.vcc_above_off <= 1'b1;
    wctl(6'h3c, 6'h30, 20);
    lv.vcc_above_off <= 1'b0;
    if (tst) begin
      lreq      <= 1'b1;
      lv.fb_low <= 1'b1;
      cyc_n(8);
      lreq      <= 1'b0;
      cyc_n(BN + 20);
      st(3'h1);
      lv.fb_low <= 1'b0;
    end
    lv.ss_done <= 1'b1;
    cyc_n(IN + 5);
    st(3'h2);
  endtask : boot

  // leave latched state by deep supply drop
  task automatic unlatch;
    st(3'h4);
    lv.vcc_unlatch <= 1'b1;
    cyc_n(5);
    lv.vcc_unlatch <= 1'b0;
    st(3'h0);
    boot(1'b0);
  endtask : unlatch

  task automatic t_reset;
    chk(ctl, 6'h0a);
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk(rd, CTRL_RST);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    chk(slv, 1'b1);
  endtask : t_reset

  task automatic t_burst;
    lv.fb_low <= 1'b1;
    cyc_n(BN - 10);
    lv.fb_low <= 1'b0;
    cyc_n(20);
    st(3'h2);
    lv.fb_low <= 1'b1;
    cyc_n(BN - 10);
    st(3'h2);
    wctl(6'h3f, 6'h07, 30);
    lv.fb_low   <= 1'b0;
    lv.burst_up <= 1'b1;
    wctl(6'h3f, 6'h37, 5);
    lv.burst_up  <= 1'b0;
    lv.burst_low <= 1'b1;
    wctl(6'h3f, 6'h07, 5);
    lv.burst_low <= 1'b0;
    lv.fb_high   <= 1'b1;
    wctl(6'h3f, 6'h32, 5);
    lv.fb_high   <= 1'b0;
  endtask : t_burst

  task automatic t_overload;
    lv.fb_high <= 1'b1;
    cyc_n(BN - 10);
    wctl(6'h02, 6'h02, 1);
    wctl(6'h02, 6'h00, 20);
    cyc_n(CAP + FL - 20);
    st(3'h2);
    wctl(6'h3c, 6'h08, 40);
    lv.fb_high <= 1'b0;
    boot(1'b0);
  endtask : t_overload

  task automatic t_short;
    lv.sec_short <= 1'b1;
    wctl(6'h30, 6'h00, 5);
    lv.sec_short <= 1'b0;
    apb(1'b0, OFF_FAULT, 32'h0000_0000);
    chk(rd[FLT_SHORT], 1'b1);
    apb(1'b1, OFF_FAULT, 32'h0000_0004);
    apb(1'b0, OFF_FAULT, 32'h0000_0000);
    chk(rd[FLT_SHORT], 1'b0);
    lv.vcc_below_on <= 1'b1;
    wctl(6'h38, 6'h08, 5);
    lv.vcc_below_on  <= 1'b0;
    lv.vcc_above_off <= 1'b1;
    wctl(6'h38, 6'h00, 5);
    cyc_n(IN + 10);
    wctl(6'h30, 6'h00, 1);
    lv.vcc_above_off <= 1'b0;
    unlatch();
  endtask : t_short

  task automatic t_filters;
    lv.vcc_over <= 1'b1;
    cyc_n(FL + 40);
    st(3'h2);
    lv.fb_high <= 1'b1;
    cyc_n(FL - 40);
    lv.fb_high <= 1'b0;
    st(3'h2);
    lv.fb_high <= 1'b1;
    wctl(6'h30, 6'h00, FL + 10);
    lv.fb_high  <= 1'b0;
    lv.vcc_over <= 1'b0;
    unlatch();
    lv.over_temp <= 1'b1;
    cyc_n(FL - 40);
    st(3'h2);
    wctl(6'h30, 6'h00, 60);
    lv.over_temp <= 1'b0;
    unlatch();
  endtask : t_filters

  task automatic t_ext;
    apb(1'b1, OFF_CTRL, 32'h0000_0002);
    lv.fb_low <= 1'b1;
    cyc_n(BN + 20);
    st(3'h2);
    lv.fb_low <= 1'b0;
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    lreq <= 1'b1;
    cyc_n(10);
    st(3'h2);
    apb(1'b1, OFF_CTRL, CTRL_RST);
    wctl(6'h30, 6'h00, 10);
    lreq <= 1'b0;
    unlatch();
  endtask : t_ext

  task automatic t_uv;
    lv.vcc_uv <= 1'b1;
    wctl(6'h38, 6'h08, 5);
    lv.vcc_uv <= 1'b0;
    st(3'h0);
    boot(1'b0);
    lv.vcc_uv    <= 1'b1;
    lv.sec_short <= 1'b1;
    cyc_n(6);
    lv.vcc_uv    <= 1'b0;
    lv.sec_short <= 1'b0;
    unlatch();
  endtask : t_uv

  // main sequence
  initial begin
    repeat (6) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    @(posedge CORE_CLK);
    t_reset();
    boot(1'b1);
    t_burst();
    t_overload();
    t_short();
    t_filters();
    t_ext();
    t_uv();
    tally_and_finish();
  end
endmodule : testbench
